/* File: sim/link_training_width_start_test.sv */
// Self-checking bench for the width-start and speed-change controller
`timescale 1ns/100ps
`default_nettype none
`include "ltws_consts.svh"
module link_training_width_start_test;
  localparam int L = 4;
  localparam int TO = 200;
  localparam logic [7:0] PAD = `LTWS_PAD_SYM;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_set_done, tx_dis, tx_lpb;
  logic rate_hi, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [L-1:0] rx_det, rx_ts_valid, rx_dis, rx_lpb, rx_rate_hi, tx_en, ts2;
  logic [L*8-1:0] rx_link, rx_lane, tx_link, tx_lane, m;
  logic [7:0] lk;
  ltws_pkg::ltws_tx_t tx_kind;
  ltws_pkg::ltws_state_t state, st;
  int failures, n_checks, cyc, gap;
  ltws_top #(.LANES(L), .TIMEOUT_CYC(TO)) i_ltws_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .rx_det(rx_det),
    .rx_ts_valid(rx_ts_valid), .rx_ts2(ts2), .rx_err('0), .rx_link(rx_link),
    .rx_lane(rx_lane), .rx_dis(rx_dis), .rx_lpb(rx_lpb), .rx_rate_hi(rx_rate_hi),
    .tx_set_done(tx_set_done), .tx_kind(tx_kind), .tx_en(tx_en), .tx_link(tx_link),
    .tx_lane(tx_lane), .tx_dis(tx_dis), .tx_lpb(tx_lpb), .rate_hi(rate_hi), .state(state));
  ltws_partner #(.LANES(L)) i_ltws_partner (.pclk(pclk), .tx_kind(tx_kind),
    .rx_ts_valid(rx_ts_valid), .rx_link(rx_link), .rx_lane(rx_lane), .rx_dis(rx_dis),
    .rx_lpb(rx_lpb), .tx_set_done(tx_set_done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask : apb
  task automatic wait_st(input ltws_pkg::ltws_state_t s, input int lim);
    cyc = 0;
    while (state !== s && cyc < lim) begin
      @(posedge pclk);
      #1;
      cyc++;
    end
    chk(state, s, "state");
  endtask : wait_st
  task automatic go(input logic [31:0] ctl, input ltws_pkg::ltws_state_t s);
    apb(1'b1, `LTWS_REG_CTRL, 32'h0);
    wait_st(ltws_pkg::LTWS_IDLE, 20);
    apb(1'b1, `LTWS_REG_CTRL, ctl);
    wait_st(s, 20);
  endtask : go
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, failures, n_checks, ts2} = '0;
    void'($urandom(98));
    rx_det = 4'($urandom_range(1, 15));
    rx_rate_hi = {L{1'($urandom_range(0, 1))}};
    for (int g = 0; g < L; g++) m[g*8+:8] = {8{rx_det[g]}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(tx_kind, ltws_pkg::LTWS_TX_TS1, "reset kind");
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    ts2 <= '1;
    i_ltws_partner.send(8, PAD, PAD, 1'b0, 1'b0, 0);
    ts2 <= '0;
    repeat (60) @(posedge pclk);
    go(32'h10, ltws_pkg::LTWS_SPD_EIOS);
    chk(tx_kind, ltws_pkg::LTWS_TX_EIOS, "eios");
    wait_st(ltws_pkg::LTWS_SPD_IDLE, 20);
    wait_st(ltws_pkg::LTWS_POLL_ACTIVE, 20);
    chk(rate_hi, rx_rate_hi[0], "rate");
    for (int dsp = 1; dsp >= 0; dsp--) begin
      lk = 8'($urandom_range(0, 239));
      gap = $urandom_range(0, 3);
      st = dsp ? ltws_pkg::LTWS_DS_START : ltws_pkg::LTWS_US_START;
      apb(1'b1, `LTWS_REG_LINK, {24'h0, lk});
      go(dsp ? 32'h9 : 32'h1, st);
      apb(1'b0, `LTWS_REG_STAT, 32'h0);
      chk(rd[8:0], {dsp[0], 4'h0, st}, "stat");
      chk(tx_en, rx_det, "tx_en");
      chk(tx_lane, {L{PAD}}, "lane");
      chk(tx_link & m, {L{dsp ? lk : PAD}} & m, "link");
      i_ltws_partner.send(1, PAD, PAD, 1'b0, 1'b0, gap);
      i_ltws_partner.send(1, lk, PAD, 1'b0, 1'b0, gap);
      i_ltws_partner.send(1, dsp ? lk ^ 8'h01 : PAD, PAD, 1'b0, 1'b0, gap);
      i_ltws_partner.send(1, lk, PAD, 1'b0, 1'b0, gap);
      chk(state, st, "held");
      i_ltws_partner.send(1, lk, PAD, 1'b0, 1'b0, gap);
      wait_st(ltws_pkg::LTWS_WIDTH_ACCEPT, 8);
      chk(tx_link & m, {L{lk}} & m, "chosen");
    end
    go(32'h9, ltws_pkg::LTWS_DS_START);
    i_ltws_partner.send(2, PAD, PAD, 1'b0, 1'b1, 1);
    wait_st(ltws_pkg::LTWS_LPB_SLAVE, 8);
    go(32'h5, ltws_pkg::LTWS_US_START);
    repeat (6) @(posedge pclk);
    #1;
    chk(state, ltws_pkg::LTWS_US_START, "no master");
    apb(1'b1, `LTWS_REG_CAP, 32'h2);
    go(32'h5, ltws_pkg::LTWS_LPB_MASTER);
    go(32'hb, ltws_pkg::LTWS_DISABLED);
    go(32'h9, ltws_pkg::LTWS_DS_START);
    wait_st(ltws_pkg::LTWS_DETECT, TO + 20);
    chk(32'(cyc > TO - 4 && cyc < TO + 4), 32'h1, "timeout");
    final_report();
  end
endmodule : link_training_width_start_test
`default_nettype wire

/* File: sim/ltws_assertions.sv */
// Port checker for the width-start and speed-change controller
`timescale 1ns/100ps
`default_nettype none
`include "ltws_consts.svh"
module ltws_checker #(
  parameter int LANES = 4,
  parameter int TIMEOUT_CYC = 200,
  parameter int IDLE_MAX_CYC = 80000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic [LANES-1:0] rx_det,
  input wire logic [LANES-1:0] rx_ts_valid,
  input wire logic [LANES-1:0] tx_en,
  input wire logic [LANES*8-1:0] tx_link,
  input wire logic [LANES*8-1:0] tx_lane,
  input wire logic tx_dis,
  input wire logic rate_hi,
  input wire ltws_pkg::ltws_tx_t tx_kind,
  input wire ltws_pkg::ltws_state_t state
);
  logic in_start;
  logic [3:0] st_prev_r;
  logic [31:0] start_cnt_r;
  logic [31:0] idle_cnt_r;
  assign in_start = state inside {ltws_pkg::LTWS_DS_START, ltws_pkg::LTWS_US_START,
                                  ltws_pkg::LTWS_US_XL_TS2};
  // Counters replace long repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_prev_r <= 4'h0;
      start_cnt_r <= 32'h0;
      idle_cnt_r <= 32'h0;
    end else begin
      st_prev_r <= state;
      start_cnt_r <= (in_start && state == st_prev_r) ? start_cnt_r + 32'h1 : 32'h0;
      idle_cnt_r <= (state == ltws_pkg::LTWS_SPD_IDLE) ? idle_cnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_eios;
    state == ltws_pkg::LTWS_SPD_EIOS;
  endsequence
  sequence s_quiet;
    state == ltws_pkg::LTWS_SPD_IDLE;
  endsequence
  AST_EIOS_KIND: assert property (s_eios |-> tx_kind == ltws_pkg::LTWS_TX_EIOS)
    else $error("idle set not sent");
  AST_EIOS_THEN_QUIET: assert property (
    s_eios ##1 (state != ltws_pkg::LTWS_SPD_EIOS) |-> s_quiet) else $error("eios skipped");
  AST_QUIET_EXIT: assert property (s_quiet |-> tx_kind == ltws_pkg::LTWS_TX_IDLE ##1
    state inside {ltws_pkg::LTWS_SPD_IDLE, ltws_pkg::LTWS_POLL_ACTIVE}) else $error("bad exit");
  AST_QUIET_MAX: assert property (idle_cnt_r < IDLE_MAX_CYC)
    else $error("idle too long");
  AST_TX_EN: assert property (in_start |-> tx_en == rx_det)
    else $error("tx lanes wrong");
  AST_LANE_PAD: assert property (in_start |-> tx_lane == {LANES{`LTWS_PAD_SYM}})
    else $error("lane not pad");
  AST_US_LINK_PAD: assert property (
    state == ltws_pkg::LTWS_US_START |-> tx_link == {LANES{`LTWS_PAD_SYM}}) else $error("link");
  AST_DIS: assert property (
    state == ltws_pkg::LTWS_DS_START && tx_dis |-> ##[1:2] state == ltws_pkg::LTWS_DISABLED)
    else $error("no disable");
  AST_TIMEOUT: assert property (start_cnt_r <= TIMEOUT_CYC + 2)
    else $error("no timeout");
  AST_ACCEPT_CAUSE: assert property ($rose(state == ltws_pkg::LTWS_WIDTH_ACCEPT) |->
    $past(|rx_ts_valid) || $past(|rx_ts_valid, 2)) else $error("accept without set");
  AST_RATE_HOLD: assert property (in_start |=> $stable(rate_hi))
    else $error("rate moved");
  AST_UNMAPPED: assert property (psel && !penable && paddr > `LTWS_REG_RATE |=> pslverr)
    else $error("unmapped not refused");
endmodule : ltws_checker
bind ltws_top ltws_checker #(.LANES(LANES), .TIMEOUT_CYC(TIMEOUT_CYC),
  .IDLE_MAX_CYC(IDLE_MAX_CYC)) i_ltws_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .rx_det(rx_det),
  .rx_ts_valid(rx_ts_valid), .tx_en(tx_en), .tx_link(tx_link), .tx_lane(tx_lane),
  .tx_dis(tx_dis), .rate_hi(rate_hi), .tx_kind(tx_kind), .state(state));
`default_nettype wire

/* File: sim/ltws_partner.sv */
// Link partner model sending training sets on every lane
`timescale 1ns/100ps
`default_nettype none
module ltws_partner #(
  parameter int LANES = 4
) (
  input wire logic pclk,
  input wire ltws_pkg::ltws_tx_t tx_kind,
  output logic [LANES-1:0] rx_ts_valid,
  output logic [LANES*8-1:0] rx_link,
  output logic [LANES*8-1:0] rx_lane,
  output logic [LANES-1:0] rx_dis,
  output logic [LANES-1:0] rx_lpb,
  output logic tx_set_done
);
  logic [1:0] sym_cnt;
  initial begin
    {rx_ts_valid, rx_link, rx_lane, rx_dis, rx_lpb, tx_set_done, sym_cnt} = '0;
  end
  // One set done every fourth cycle unless idle
  always @(posedge pclk) begin
    sym_cnt <= sym_cnt + 2'h1;
    tx_set_done <= sym_cnt == 2'h3 && tx_kind != ltws_pkg::LTWS_TX_IDLE;
  end
  // Between sets the fields show the inverse, so stale values never pass
  task automatic send(input int n, input logic [7:0] lk, input logic [7:0] ln,
                      input logic dis, input logic lpb, input int gap);
    repeat (n) begin
      @(posedge pclk);
      rx_ts_valid <= '1;
      rx_link <= {LANES{lk}};
      rx_lane <= {LANES{ln}};
      rx_dis <= {LANES{dis}};
      rx_lpb <= {LANES{lpb}};
      @(posedge pclk);
      rx_ts_valid <= '0;
      rx_link <= ~{LANES{lk}};
      rx_lane <= ~{LANES{ln}};
      rx_dis <= {LANES{~dis}};
      rx_lpb <= {LANES{~lpb}};
      repeat (gap) @(posedge pclk);
    end
    #1;
  endtask : send
endmodule : ltws_partner
`default_nettype wire

/* File: src/ltws_consts.svh */
// Constants for the link training width-start and speed-change block
`ifndef LTWS_CONSTS_SVH
`define LTWS_CONSTS_SVH
`define LTWS_CLK_MHZ 40
`define LTWS_PAD_SYM 8'hf7
`define LTWS_IDLE_MIN_NS 20
`define LTWS_IDLE_MAX_US 2000
`define LTWS_TIMEOUT_US 24000
`define LTWS_IDLE_MIN_CYC ((`LTWS_IDLE_MIN_NS * `LTWS_CLK_MHZ + 999) / 1000)
`define LTWS_IDLE_MAX_CYC (`LTWS_IDLE_MAX_US * `LTWS_CLK_MHZ)
`define LTWS_TIMEOUT_CYC (`LTWS_TIMEOUT_US * `LTWS_CLK_MHZ)
`define LTWS_XL_TS_MIN 16
`define LTWS_XL_TS_MAX 32
`define LTWS_MATCH_CNT 2
`define LTWS_ERR_DEFER 2
`define LTWS_SPD_TS2_RX 8
`define LTWS_SPD_TS2_TX 16
`define LTWS_REG_CTRL 12'h000
`define LTWS_REG_CAP 12'h004
`define LTWS_REG_LINK 12'h008
`define LTWS_REG_STAT 12'h00c
`define LTWS_REG_XLTO 12'h010
`define LTWS_REG_RATE 12'h014
`define LTWS_CTRL_START 0
`define LTWS_CTRL_DIS 1
`define LTWS_CTRL_LPB 2
`define LTWS_CTRL_DSP 3
`define LTWS_CTRL_SPEED 4
`define LTWS_CAP_XL 0
`define LTWS_CAP_LPM 1
`define LTWS_CAP_MULTI 2
`endif

/* File: src/ltws_lane_cnt.sv */
// Per-lane counter of consecutive matching TS1 sets
`timescale 1ns/100ps
`default_nettype none
`include "ltws_consts.svh"
module ltws_lane_cnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic ts_valid,
  input wire logic ts_match,
  input wire logic ts_err,
  output logic hit
);
  logic [2:0] cnt_r;
  // Any non-matching or errored set resets the run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
    end else if (clr) begin
      cnt_r <= 3'h0;
    end else if (ts_valid) begin
      if (ts_match && !ts_err) begin
        if (cnt_r != 3'h7) begin
          cnt_r <= cnt_r + 3'h1;
        end
      end else begin
        cnt_r <= 3'h0;
      end
    end
  end
  assign hit = (cnt_r >= 3'(`LTWS_MATCH_CNT));
endmodule : ltws_lane_cnt
`default_nettype wire

/* File: src/ltws_pkg.sv */
// Types for the link training width-start and speed-change block
package ltws_pkg;
  typedef enum logic [3:0] {
    LTWS_IDLE,
    LTWS_SPD_EIOS,
    LTWS_SPD_IDLE,
    LTWS_POLL_ACTIVE,
    LTWS_DS_START,
    LTWS_US_START,
    LTWS_US_XL_TS2,
    LTWS_WIDTH_ACCEPT,
    LTWS_DISABLED,
    LTWS_LPB_MASTER,
    LTWS_LPB_SLAVE,
    LTWS_DETECT
  } ltws_state_t;
  typedef enum logic [1:0] {
    LTWS_TX_TS1,
    LTWS_TX_TS2,
    LTWS_TX_EIOS,
    LTWS_TX_IDLE
  } ltws_tx_t;
endpackage : ltws_pkg

/* File: src/ltws_top.sv */
// Link width-start and speed-change training controller with APB registers
// Summary of operation
// - On speed change, transmitter idles at least minimum idle time, at most 2 ms
// - An electrical idle ordered set is sent before going idle
// - Switch to the higher rate if any detected lane advertises it, then return to active polling
// - Downstream port goes disabled when directed to set the disable bit
// - Either facing goes loopback master when directed and master-capable
// - Crosslink downstream goes disabled when all TS1 lanes see disable twice
// - Enter loopback slave when all receiving lanes see loopback bit twice
// - Downstream lanes send TS1 with selected link numbers and pad lane numbers
// - Distinct link numbers only on lane groups able to form separate links
// - Downstream goes width-accept after two matching non-pad-link pad-lane TS1
// - Crosslink downstream sends 16-32 TS1, then flips upstream on such TS1
// - Crosslink timeout is random to break symmetric deadlock
// - Pad then non-pad TS1 sequence is invalid if a TS2 came between
// - Either facing returns to detect after 24 ms in width-start
// - Upstream port obeys directed disable only when crosslink-capable
// - Upstream disables on any lane seeing disable twice; crosslink needs all
// - Upstream lanes send TS1 with pad link and pad lane numbers
// - Upstream echoes one link number on matching lanes, pad elsewhere, accepts
// - Multi-lane link with TS1 errors defers evaluation by two more sets
// - Crosslink upstream sends 16-32 pad TS1, then selects normally on non-pad-link TS1
// - On crosslink timeout, upstream sends 16-32 pad TS2 and becomes downstream
// - Speed change entered when directed; higher rate only after 8 TS2 received and 16 sets sent
`timescale 1ns/100ps
`default_nettype none
`include "ltws_consts.svh"
module ltws_top #(
  parameter int LANES = 4,
  parameter int TIMEOUT_CYC = `LTWS_TIMEOUT_CYC,
  parameter int IDLE_MAX_CYC = `LTWS_IDLE_MAX_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [LANES-1:0] rx_det,
  input wire logic [LANES-1:0] rx_ts_valid,
  input wire logic [LANES-1:0] rx_ts2,
  input wire logic [LANES-1:0] rx_err,
  input wire logic [LANES*8-1:0] rx_link,
  input wire logic [LANES*8-1:0] rx_lane,
  input wire logic [LANES-1:0] rx_dis,
  input wire logic [LANES-1:0] rx_lpb,
  input wire logic [LANES-1:0] rx_rate_hi,
  input wire logic tx_set_done,
  output ltws_pkg::ltws_tx_t tx_kind,
  output logic [LANES-1:0] tx_en,
  output logic [LANES*8-1:0] tx_link,
  output logic [LANES*8-1:0] tx_lane,
  output logic tx_dis,
  output logic tx_lpb,
  output logic rate_hi,
  output ltws_pkg::ltws_state_t state
);
  localparam logic [7:0] PAD = `LTWS_PAD_SYM;
  localparam int IDLE_MIN = (`LTWS_IDLE_MIN_CYC < 1) ? 1 : `LTWS_IDLE_MIN_CYC;

  ltws_pkg::ltws_state_t state_r;
  ltws_pkg::ltws_state_t state_nxt;
  logic [4:0] ctrl_r;
  logic [2:0] cap_r;
  logic [31:0] link_r;
  logic [15:0] xlto_r;
  logic [31:0] tmr_r;
  logic [5:0] txcnt_r;
  logic [15:0] lfsr_r;
  logic [15:0] xl_tmr_r;
  logic [3:0] ts2rx_r;
  logic [4:0] ts2tx_r;
  logic dsp_r;
  logic xl_sent_r;
  logic [LANES-1:0] pad_seen_r;
  logic [LANES-1:0] ts2_int_r;
  logic [LANES-1:0] err_seen_r;
  logic [LANES-1:0] rcv_r;
  logic [1:0] defer_r;
  logic [7:0] sel_link_r;
  logic [LANES-1:0] sel_lanes_r;
  logic [LANES-1:0] hit_nplink;
  logic [LANES-1:0] hit_padpad;
  logic [LANES-1:0] hit_dis;
  logic [LANES-1:0] hit_lpb;
  logic [LANES-1:0] active;
  logic in_start;
  logic entry;
  logic apb_wr;
  logic ds_accept;
  logic us_sel;
  logic all_dis;
  logic any_dis;
  logic all_lpb;
  logic xl;
  logic [5:0] xl_target;

  // Link number assigned to a lane: one per separately formable group
  function automatic logic [7:0] lane_link(input int idx, input logic [31:0] lr,
                                           input logic multi);
    lane_link = (multi && idx >= LANES / 2) ? lr[15:8] : lr[7:0];
  endfunction

  function automatic logic nonpad_match(input logic [7:0] lk, input logic [31:0] lr,
                                        input logic multi);
    nonpad_match = (lk != PAD) && ((lk == lr[7:0]) || (multi && lk == lr[15:8]));
  endfunction

  assign xl = cap_r[`LTWS_CAP_XL];
  assign in_start = (state_r == ltws_pkg::LTWS_DS_START) ||
                    (state_r == ltws_pkg::LTWS_US_START);
  assign entry = (state_r != state_nxt);
  // Receiving means a set arrived since entry, not a strobe in this cycle
  assign active = rcv_r;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [7:0] lk;
      logic [7:0] ln;
      assign lk = rx_link[g*8 +: 8];
      assign ln = rx_lane[g*8 +: 8];
      // Downstream awaits its own link number back; upstream any non-pad
      ltws_lane_cnt u_np (
        .pclk(pclk), .presetn(presetn), .clr(entry), .ts_valid(rx_ts_valid[g]),
        .ts_match(!rx_ts2[g] && ln == PAD && (dsp_r ?
                  nonpad_match(lk, link_r, cap_r[`LTWS_CAP_MULTI]) : lk != PAD)),
        .ts_err(rx_err[g]), .hit(hit_nplink[g]));
      ltws_lane_cnt u_pp (
        .pclk(pclk), .presetn(presetn), .clr(entry), .ts_valid(rx_ts_valid[g]),
        .ts_match(!rx_ts2[g] && lk == PAD && ln == PAD),
        .ts_err(rx_err[g]), .hit(hit_padpad[g]));
      ltws_lane_cnt u_ds (
        .pclk(pclk), .presetn(presetn), .clr(entry), .ts_valid(rx_ts_valid[g]),
        .ts_match(!rx_ts2[g] && rx_dis[g]), .ts_err(rx_err[g]), .hit(hit_dis[g]));
      ltws_lane_cnt u_lb (
        .pclk(pclk), .presetn(presetn), .clr(entry), .ts_valid(rx_ts_valid[g]),
        .ts_match(!rx_ts2[g] && rx_lpb[g]), .ts_err(rx_err[g]), .hit(hit_lpb[g]));
      // Pad-first and TS2-interruption tracking per lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_seen_r[g] <= 1'b0;
          ts2_int_r[g] <= 1'b0;
        end else if (entry) begin
          pad_seen_r[g] <= 1'b0;
          ts2_int_r[g] <= 1'b0;
        end else if (rx_ts_valid[g]) begin
          if (!rx_ts2[g] && lk == PAD && ln == PAD) begin
            pad_seen_r[g] <= 1'b1;
            ts2_int_r[g] <= 1'b0;
          end else if (rx_ts2[g] && pad_seen_r[g]) begin
            ts2_int_r[g] <= 1'b1;
          end
        end
      end
      assign tx_link[g*8 +: 8] = (dsp_r) ? lane_link(g, link_r, cap_r[`LTWS_CAP_MULTI]) :
                                 (sel_lanes_r[g] ? sel_link_r : PAD);
      assign tx_lane[g*8 +: 8] = PAD;
    end
  endgenerate

  // Without crosslink the pad-first condition counts as always met
  assign ds_accept = |(hit_nplink & rx_det & (xl ? (pad_seen_r & ~ts2_int_r) :
                       {LANES{1'b1}})) && (!xl || xl_sent_r) && defer_r == 2'h0;
  assign us_sel = |(hit_nplink & rx_det) && defer_r == 2'h0;
  assign all_dis = (|active) && ((hit_dis & active) == active);
  assign any_dis = |(hit_dis & rx_det);
  assign all_lpb = (|active) && ((hit_lpb & active) == active);
  assign xl_target = 6'(`LTWS_XL_TS_MIN);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ltws_pkg::LTWS_IDLE: begin
        if (ctrl_r[`LTWS_CTRL_SPEED]) begin
          state_nxt = ltws_pkg::LTWS_SPD_EIOS;
        end else if (ctrl_r[`LTWS_CTRL_START]) begin
          state_nxt = ctrl_r[`LTWS_CTRL_DSP] ? ltws_pkg::LTWS_DS_START :
                      ltws_pkg::LTWS_US_START;
        end
      end
      ltws_pkg::LTWS_SPD_EIOS: begin
        if (tx_set_done) begin
          state_nxt = ltws_pkg::LTWS_SPD_IDLE;
        end
      end
      ltws_pkg::LTWS_SPD_IDLE: begin
        if (tmr_r >= 32'(IDLE_MIN) - 32'h1) begin
          state_nxt = ltws_pkg::LTWS_POLL_ACTIVE;
        end
      end
      ltws_pkg::LTWS_DS_START: begin
        if (tmr_r >= 32'(TIMEOUT_CYC) - 32'h1) begin
          state_nxt = ltws_pkg::LTWS_DETECT;
        end else if (ctrl_r[`LTWS_CTRL_DIS]) begin
          state_nxt = ltws_pkg::LTWS_DISABLED;
        end else if (ctrl_r[`LTWS_CTRL_LPB] && cap_r[`LTWS_CAP_LPM]) begin
          state_nxt = ltws_pkg::LTWS_LPB_MASTER;
        end else if (xl && all_dis) begin
          state_nxt = ltws_pkg::LTWS_DISABLED;
        end else if (all_lpb) begin
          state_nxt = ltws_pkg::LTWS_LPB_SLAVE;
        end else if (ds_accept) begin
          state_nxt = ltws_pkg::LTWS_WIDTH_ACCEPT;
        end else if (xl && xl_sent_r && |(hit_nplink & rx_det)) begin
          state_nxt = ltws_pkg::LTWS_US_START;
        end
      end
      ltws_pkg::LTWS_US_START: begin
        if (tmr_r >= 32'(TIMEOUT_CYC) - 32'h1) begin
          state_nxt = ltws_pkg::LTWS_DETECT;
        end else if (xl && ctrl_r[`LTWS_CTRL_DIS]) begin
          state_nxt = ltws_pkg::LTWS_DISABLED;
        end else if (ctrl_r[`LTWS_CTRL_LPB] && cap_r[`LTWS_CAP_LPM]) begin
          state_nxt = ltws_pkg::LTWS_LPB_MASTER;
        end else if (xl ? all_dis : any_dis) begin
          state_nxt = ltws_pkg::LTWS_DISABLED;
        end else if (all_lpb) begin
          state_nxt = ltws_pkg::LTWS_LPB_SLAVE;
        end else if (us_sel && (!xl || xl_sent_r)) begin
          state_nxt = ltws_pkg::LTWS_WIDTH_ACCEPT;
        end else if (xl && xl_sent_r && xl_tmr_r == 16'h0) begin
          state_nxt = ltws_pkg::LTWS_US_XL_TS2;
        end
      end
      ltws_pkg::LTWS_US_XL_TS2: begin
        if (txcnt_r >= xl_target) begin
          state_nxt = ltws_pkg::LTWS_DS_START;
        end
      end
      default: begin
        if (!ctrl_r[`LTWS_CTRL_START] && !ctrl_r[`LTWS_CTRL_SPEED]) begin
          state_nxt = ltws_pkg::LTWS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ltws_pkg::LTWS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Facing flips on crosslink resolution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsp_r <= 1'b0;
    end else if (state_r == ltws_pkg::LTWS_IDLE) begin
      dsp_r <= ctrl_r[`LTWS_CTRL_DSP];
    end else if (state_nxt == ltws_pkg::LTWS_US_START && state_r == ltws_pkg::LTWS_DS_START) begin
      dsp_r <= 1'b0;
    end else if (state_nxt == ltws_pkg::LTWS_DS_START && state_r == ltws_pkg::LTWS_US_XL_TS2) begin
      dsp_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= 32'h0;
    end else if (entry) begin
      tmr_r <= 32'h0;
    end else begin
      tmr_r <= tmr_r + 32'h1;
    end
  end

  // Sets sent since entry; crosslink pre-send counts 16 before acting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcnt_r <= 6'h0;
      xl_sent_r <= 1'b0;
    end else if (entry) begin
      txcnt_r <= 6'h0;
      xl_sent_r <= 1'b0;
    end else if (tx_set_done && txcnt_r != 6'(`LTWS_XL_TS_MAX)) begin
      txcnt_r <= txcnt_r + 6'h1;
      if (txcnt_r + 6'h1 >= xl_target) begin
        xl_sent_r <= 1'b1;
      end
    end
  end

  // Free-running LFSR seeds a fresh random crosslink timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 16'hace1;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xl_tmr_r <= 16'h0;
    end else if (entry && state_nxt == ltws_pkg::LTWS_US_START) begin
      xl_tmr_r <= xlto_r | (lfsr_r & (xlto_r >> 1));
    end else if (xl_tmr_r != 16'h0) begin
      xl_tmr_r <= xl_tmr_r - 16'h1;
    end
  end

  // With the multi-lane capability set, lanes with errors hold off width evaluation by two further sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_seen_r <= '0;
      rcv_r <= '0;
      defer_r <= 2'h0;
    end else if (entry) begin
      err_seen_r <= '0;
      rcv_r <= '0;
      defer_r <= 2'h0;
    end else begin
      err_seen_r <= err_seen_r | (rx_err & rx_ts_valid & rx_det);
      rcv_r <= rcv_r | (rx_ts_valid & rx_det);
      if (cap_r[`LTWS_CAP_MULTI] && |(rx_err & rx_ts_valid & rx_det) && !(&err_seen_r)) begin
        defer_r <= 2'(`LTWS_ERR_DEFER);
      end else if (defer_r != 2'h0 && |rx_ts_valid) begin
        defer_r <= defer_r - 2'h1;
      end
    end
  end

  // Upstream selection latches a single link number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_link_r <= 8'hf7;
      sel_lanes_r <= '0;
    end else if (entry && state_nxt == ltws_pkg::LTWS_WIDTH_ACCEPT && !dsp_r) begin
      sel_lanes_r <= hit_nplink & rx_det;
    end else if (entry) begin
      sel_lanes_r <= '0;
    end else if (state_r == ltws_pkg::LTWS_US_START) begin
      // Numbers are read only under their strobe; between sets the lanes carry junk
      for (int i = LANES - 1; i >= 0; i--) begin
        if (rx_ts_valid[i] && rx_det[i] && rx_link[i*8 +: 8] != PAD) begin
          sel_link_r <= rx_link[i*8 +: 8];
        end
      end
    end
  end

  // Higher-rate qualifying counters: 8 TS2 received, 16 sets sent after the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts2rx_r <= 4'h0;
      ts2tx_r <= 5'h0;
      rate_hi <= 1'b0;
    end else begin
      if (|(rx_ts_valid & rx_ts2 & rx_det)) begin
        ts2rx_r <= (ts2rx_r == 4'(`LTWS_SPD_TS2_RX)) ? ts2rx_r : ts2rx_r + 4'h1;
      end
      if (ts2rx_r != 4'h0 && tx_set_done && ts2tx_r != 5'(`LTWS_SPD_TS2_TX)) begin
        ts2tx_r <= ts2tx_r + 5'h1;
      end
      if (state_r == ltws_pkg::LTWS_SPD_IDLE && entry) begin
        rate_hi <= |(rx_rate_hi & rx_det) && ts2rx_r == 4'(`LTWS_SPD_TS2_RX) &&
                   ts2tx_r == 5'(`LTWS_SPD_TS2_TX);
      end
    end
  end

  always_comb begin
    case (state_r)
      ltws_pkg::LTWS_SPD_EIOS: tx_kind = ltws_pkg::LTWS_TX_EIOS;
      ltws_pkg::LTWS_SPD_IDLE: tx_kind = ltws_pkg::LTWS_TX_IDLE;
      ltws_pkg::LTWS_US_XL_TS2: tx_kind = ltws_pkg::LTWS_TX_TS2;
      default: tx_kind = ltws_pkg::LTWS_TX_TS1;
    endcase
  end
  assign tx_en = (in_start || state_r == ltws_pkg::LTWS_US_XL_TS2) ? rx_det : '0;
  assign tx_dis = ctrl_r[`LTWS_CTRL_DIS];
  assign tx_lpb = ctrl_r[`LTWS_CTRL_LPB];
  assign state = state_r;

  // APB slave: zero wait states, unmapped addresses give pslverr
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 5'h0;
      cap_r <= 3'h0;
      link_r <= 32'h0000_0100;
      xlto_r <= 16'h0400;
    end else begin
      if (apb_wr && paddr == `LTWS_REG_CTRL) begin
        ctrl_r <= pwdata[4:0];
      end else if (state_r == ltws_pkg::LTWS_POLL_ACTIVE) begin
        ctrl_r[`LTWS_CTRL_SPEED] <= 1'b0;
      end
      if (apb_wr && paddr == `LTWS_REG_CAP) begin
        cap_r <= pwdata[2:0];
      end
      if (apb_wr && paddr == `LTWS_REG_LINK) begin
        link_r <= pwdata;
      end
      if (apb_wr && paddr == `LTWS_REG_XLTO) begin
        xlto_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `LTWS_REG_CTRL: prdata <= {27'h0, ctrl_r};
          `LTWS_REG_CAP: prdata <= {29'h0, cap_r};
          `LTWS_REG_LINK: prdata <= link_r;
          `LTWS_REG_STAT: prdata <= {23'h0, dsp_r, 4'h0, state_r};
          `LTWS_REG_XLTO: prdata <= {16'h0, xlto_r};
          `LTWS_REG_RATE: prdata <= {31'h0, rate_hi};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : ltws_top
`default_nettype wire
